// [clkgen_dev_model.sv]
// Behavioural model of the clock generator registers behind the device port.
// Assumes the host's four-phase handshake; dly_i sets the answer delay.
`timescale 1ns/10ps
module clkgen_dev_model (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        req_i,
   input  wire        we_i,
   input  wire [15:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire [3:0]  be_i,
   input  wire [3:0]  dly_i,
   input  wire        stop_i,
   output reg         ack_o,
   output wire [31:0] rdata_o
);
   reg  [3:0] cnt_q;
   reg  [7:0] key_q, prot_q, osc0_q, osc1_q, osc2_q, ls_q, mode2_q, div_q, rd_q, sel;
   wire [7:0] wd   = wdata_i[7:0];
   wire       lock = mode2_q[1];
   // ====
   // Released bus shows the inverse of the last value
   assign rdata_o = ack_o ? {24'h0, rd_q} : ~{24'h0, rd_q};
   always @* begin
      case (addr_i)
         16'h0011: sel = osc1_q;
         16'h0012: sel = osc2_q;
         16'h0014: sel = mode2_q;
         default:  sel = osc0_q;
      endcase
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {ack_o, cnt_q, rd_q} <= 13'h0;
         {key_q, prot_q, osc0_q, osc1_q, osc2_q, ls_q, mode2_q, div_q} <= 64'h0;
      end else begin
         if (!req_i) begin
            {ack_o, cnt_q} <= 5'h0;
         end else if (!ack_o && cnt_q != dly_i) begin
            cnt_q <= cnt_q + 4'h1;
         end else if (!ack_o) begin
            ack_o <= 1'b1;
            rd_q  <= sel;
            if (we_i) begin
               case (addr_i)
                  16'h0004: if (key_q == 8'haa) div_q <= {wd[7], be_i == 4'hf ? wd[6] : div_q[6], wd[5:0]};
                  16'h0008: key_q <= wd;
                  16'h000a: prot_q <= wd;
                  16'h0010: if (prot_q[0]) osc0_q <= lock ? {wd[7:6], osc0_q[5], wd[4:3], osc0_q[2], wd[1:0]} : wd;
                  16'h0011: if (prot_q[0]) osc1_q <= wd;
                  16'h0012: if (prot_q[0]) osc2_q <= {wd[7:3], wd[2] & osc2_q[2], wd[1], lock ? osc2_q[0] : wd[0]};
                  16'h0013: ls_q <= wd;
                  16'h0014: if (prot_q[1]) mode2_q <= wd | (mode2_q & 8'h02);
                  default: ;
               endcase
            end
         end
         if (stop_i) begin
            osc1_q[5] <= 1'b1;
            osc2_q[2] <= 1'b1;
         end
      end
   end
endmodule // clkgen_dev_model

// [clkgen_host.v]
// Host controller that programs the clock generator of a microcontroller.
// Assumes software drives the Avalon-MM slave and the device register
// port answers by a four-phase handshake.
//
// How it works
// - Host loads the protect key with AAh once before the divider register writes of each command.
// - Host sets the oscillator unlock bit before writing oscillator control registers.
// - Host sets the mode 2 unlock bit before writing the mode 2 register.
// - Host clears the stop status only after a main oscillator stabilization wait.
// - Host keeps stop detection off while main divided by 256 is base clock.
// - Host sets the designated divider bit only by one full 32-bit write.
// - Host refuses divider settings where CPU ratio exceeds peripheral ratio.
// - Host changes base and peripheral ratios in two separate writes.
// - Host sets sub pins to input, pull-up off, then enables the sub oscillator.
// - For external sub clock host clears output pin direction and pull-up first.
// - Host waits for sub stability after enabling it; switching selects sub clock, then sets base source select.
`timescale 1ns/10ps
`include "clkgen_host_regs.vh"

module clkgen_host #(
   parameter SUB_STAB_CYC  = (`SUB_STAB_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter MAIN_STAB_CYC = (`MAIN_STAB_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire        CLK_I,
   input  wire        RST_N_I,
   input  wire [1:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   output reg  [31:0] AVS_READDATA_O,
   output reg         AVS_WAITREQUEST_O,
   output wire        DEV_REQ_O,
   output wire        DEV_WE_O,
   output wire [15:0] DEV_ADDR_O,
   output wire [31:0] DEV_WDATA_O,
   output wire [3:0]  DEV_BE_O,
   input  wire        DEV_ACK_I,
   input  wire [31:0] DEV_RDATA_I
);

   localparam S_IDLE  = 4'b0001;
   localparam S_STEP  = 4'b0010;
   localparam S_BUS   = 4'b0100;
   localparam S_DELAY = 4'b1000;

   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [2:0]  cmd_q;
   reg  [2:0]  idx_q;
   reg  [23:0] cnt_q;
   reg  [7:0]  div_cfg_q;
   reg  [15:0] misc_q;
   reg  [15:0] raddr_q;
   reg  [31:0] rd_data_q;
   reg  [7:0]  ccr_shadow_q;
   reg         err_q;
   reg         start_q;
   reg  [53:0] step_q;
   wire [53:0] step_w;
   wire        port_done;
   wire [31:0] port_rdata;
   wire        acc;
   wire        cmd_wr;

   // ========================================================
   // Field helpers
   function [1:0] fld;
      input [7:0] v;
      input [2:0] lsb;
      begin
         fld = v[lsb +: `DIV_FIELD_W];
      end
   endfunction

   function [53:0] mk;
      input [1:0]  op;
      input [3:0]  be;
      input [15:0] addr;
      input [7:0]  data;
      begin
         mk = {op, be, addr, 24'h00_0000, data};
      end
   endfunction

   // ========================================================
   // Command sequences
   function [53:0] step_fn;
      input [2:0]  cmd;
      input [2:0]  idx;
      input [7:0]  div;
      input [15:0] misc;
      input [15:0] raddr;
      input [7:0]  clock_divider_ctrl;
      reg   [7:0]  osc0;
      reg   [7:0]  dir;
      reg   [7:0]  ccr_a;
      reg   [7:0]  ccr_b;
      reg          det_en;
      begin
         osc0 = `BYTE_ZERO;
         osc0[`OSC0_WAIT_STOP_BIT] = misc[`MISC_WAIT_STOP_BIT];
         osc0[`OSC0_MAIN_DIS_BIT]  = misc[`MISC_MAIN_DIS_BIT];
         dir = `BYTE_ZERO;
         ccr_a = clock_divider_ctrl;
         ccr_a[`DIV_BASE_LSB +: `DIV_FIELD_W] = fld(div, `DIV_BASE_LSB);
         ccr_a[`DIV_CPU_LSB +: `DIV_FIELD_W]  = fld(div, `DIV_CPU_LSB);
         ccr_b = ccr_a;
         ccr_b[`DIV_PERIPH_LSB +: `DIV_FIELD_W] = fld(div, `DIV_PERIPH_LSB);
         ccr_b[`DIV_ONCE_BIT] = clock_divider_ctrl[`DIV_ONCE_BIT] | div[`DIV_ONCE_BIT];
         det_en = misc[`MISC_STOP_DET_BIT] &
                  ~((misc[`MISC_LS_SEL_LSB +: 2] == `LS_SEL_MAIN256) & clock_divider_ctrl[`DIV_BASE_SRC_BIT]);
         step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
         case (cmd)
            `CMD_START_SUB: begin
               case (idx)
                  3'h0: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_OSC_UNLOCK);
                  3'h1: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PORT_DIR_ADDR, dir);
                  3'h2: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PULLUP_ADDR, `BYTE_ZERO);
                  3'h3: begin
                     osc0[`OSC0_SUB_EN_BIT] = 1'b1;
                     step_fn = mk(`OP_WR, `BE_BYTE, `DEV_OSC0_ADDR, osc0);
                  end
                  3'h4: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_NONE);
                  3'h5: step_fn = {`OP_WAIT, `BE_BYTE, 16'h0000, `WAIT_SUB};
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_SWITCH_SUB: begin
               ccr_a = clock_divider_ctrl;
               ccr_a[`DIV_BASE_SRC_BIT] = 1'b1;
               case (idx)
                  3'h0: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_LOW_SPEED_ADDR, {6'h00, `LS_SEL_SUB});
                  3'h1: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_KEY_ADDR, `KEY_UNLOCK);
                  3'h2: step_fn = mk(`OP_WR, `BE_WORD, `DEV_CLK_DIV_ADDR, ccr_a);
                  3'h3: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_KEY_ADDR, `KEY_LOCK);
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_SET_DIV: begin
               case (idx)
                  3'h0: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_KEY_ADDR, `KEY_UNLOCK);
                  3'h1: step_fn = mk(`OP_WR, `BE_WORD, `DEV_CLK_DIV_ADDR, ccr_a);
                  3'h2: step_fn = mk(`OP_WR, `BE_WORD, `DEV_CLK_DIV_ADDR, ccr_b);
                  3'h3: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_KEY_ADDR, `KEY_LOCK);
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_MAIN_CTRL: begin
               case (idx)
                  3'h0: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_OSC_UNLOCK);
                  3'h1: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_OSC2_ADDR,
                                     {7'h00, det_en & ~misc[`MISC_MAIN_DIS_BIT]});
                  3'h2: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_OSC0_ADDR, osc0);
                  3'h3: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_NONE);
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_CLEAR_STOP: begin
               case (idx)
                  3'h0: step_fn = {`OP_WAIT, `BE_BYTE, 16'h0000, `WAIT_MAIN};
                  3'h1: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_OSC_UNLOCK);
                  3'h2: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_OSC1_ADDR, `BYTE_ZERO);
                  3'h3: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_OSC2_ADDR, {7'h00, det_en});
                  3'h4: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_NONE);
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_SET_MODE2: begin
               case (idx)
                  3'h0: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_MODE2_UNLOCK);
                  3'h1: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_MODE2_ADDR, misc[`MISC_MODE2_LSB +: 8]);
                  3'h2: step_fn = mk(`OP_WR, `BE_BYTE, `DEV_PROT_ADDR, `PROT_NONE);
                  default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               endcase
            end
            `CMD_READ: begin
               if (idx == 3'h0) begin
                  step_fn = mk(`OP_RD, `BE_WORD, raddr, `BYTE_ZERO);
               end else begin
                  step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
               end
            end
            default: step_fn = mk(`OP_END, `BE_BYTE, 16'h0000, `BYTE_ZERO);
         endcase
      end
   endfunction

   // Divide codes grow with the ratio
   function ratio_ok;
      input [7:0] div;
      begin
         ratio_ok = fld(div, `DIV_CPU_LSB) <= fld(div, `DIV_PERIPH_LSB);
      end
   endfunction

   assign step_w = step_fn(cmd_q, idx_q, div_cfg_q, misc_q, raddr_q, ccr_shadow_q);

   // ========================================================
   // Avalon-MM slave, one wait cycle per access
   assign acc    = (AVS_READ_I | AVS_WRITE_I) & ~AVS_WAITREQUEST_O;
   assign cmd_wr = acc & AVS_WRITE_I & (AVS_ADDRESS_I == `CSR_CMD) & (state_q == S_IDLE);

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O    <= 32'h0000_0000;
         div_cfg_q         <= 8'h00;
         misc_q            <= 16'h0000;
         raddr_q           <= 16'h0000;
      end else begin
         AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
         if ((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O) begin
            case (AVS_ADDRESS_I)
               `CSR_CMD:  AVS_READDATA_O <= {22'h00_0000, err_q, state_q != S_IDLE, 5'h00, cmd_q};
               `CSR_DIV:  AVS_READDATA_O <= {24'h00_0000, div_cfg_q};
               `CSR_MISC: AVS_READDATA_O <= {16'h0000, misc_q};
               `CSR_READ: AVS_READDATA_O <= rd_data_q;
               default:   AVS_READDATA_O <= 32'h0000_0000;
            endcase
         end
         if (acc & AVS_WRITE_I) begin
            case (AVS_ADDRESS_I)
               `CSR_DIV:  div_cfg_q <= AVS_WRITEDATA_I[7:0];
               `CSR_MISC: misc_q    <= AVS_WRITEDATA_I[15:0];
               `CSR_READ: raddr_q   <= AVS_WRITEDATA_I[15:0];
               default:   raddr_q   <= raddr_q;
            endcase
         end
      end
   end

   // ========================================================
   // Sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (cmd_wr && AVS_WRITEDATA_I[2:0] != `CMD_NONE &&
                !(AVS_WRITEDATA_I[2:0] == `CMD_SET_DIV && !ratio_ok(div_cfg_q))) begin
               state_d = S_STEP;
            end
         end
         S_STEP: begin
            case (step_w[53:52])
               `OP_END:  state_d = S_IDLE;
               `OP_WAIT: state_d = S_DELAY;
               default:  state_d = S_BUS;
            endcase
         end
         S_BUS:   state_d = port_done ? S_STEP : S_BUS;
         S_DELAY: state_d = (cnt_q == 24'h00_0000) ? S_STEP : S_DELAY;
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q      <= S_IDLE;
         cmd_q        <= `CMD_NONE;
         idx_q        <= 3'h0;
         cnt_q        <= 24'h00_0000;
         err_q        <= 1'b0;
         start_q      <= 1'b0;
         step_q       <= 54'h0;
         rd_data_q    <= 32'h0000_0000;
         ccr_shadow_q <= 8'h00;
      end else begin
         state_q <= state_d;
         start_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (cmd_wr) begin
                  cmd_q <= AVS_WRITEDATA_I[2:0];
                  idx_q <= 3'h0;
                  err_q <= (AVS_WRITEDATA_I[2:0] == `CMD_SET_DIV) && !ratio_ok(div_cfg_q);
               end
            end
            S_STEP: begin
               step_q <= step_w;
               if (step_w[53:52] == `OP_WAIT) begin
                  cnt_q <= (step_w[31:0] == `WAIT_SUB) ? SUB_STAB_CYC[23:0] : MAIN_STAB_CYC[23:0];
               end else if (step_w[53:52] != `OP_END) begin
                  start_q <= 1'b1;
               end
            end
            S_BUS: begin
               if (port_done) begin
                  idx_q <= idx_q + 3'h1;
                  if (step_q[53:52] == `OP_RD) begin
                     rd_data_q <= port_rdata;
                  end else if (step_q[47:32] == `DEV_CLK_DIV_ADDR) begin
                     ccr_shadow_q <= step_q[7:0];
                  end
               end
            end
            S_DELAY: begin
               if (cnt_q == 24'h00_0000) begin
                  idx_q <= idx_q + 3'h1;
               end else begin
                  cnt_q <= cnt_q - 24'h00_0001;
               end
            end
            default: idx_q <= 3'h0;
         endcase
      end
   end

   // ========================================================
   // Device register port
   dev_port u_port (
      .clk_i       (CLK_I),
      .rst_n_i     (RST_N_I),
      .start_i     (start_q),
      .we_i        (step_q[53:52] == `OP_WR),
      .addr_i      (step_q[47:32]),
      .wdata_i     (step_q[31:0]),
      .be_i        (step_q[51:48]),
      .done_o      (port_done),
      .rdata_o     (port_rdata),
      .dev_req_o   (DEV_REQ_O),
      .dev_we_o    (DEV_WE_O),
      .dev_addr_o  (DEV_ADDR_O),
      .dev_wdata_o (DEV_WDATA_O),
      .dev_be_o    (DEV_BE_O),
      .dev_ack_i   (DEV_ACK_I),
      .dev_rdata_i (DEV_RDATA_I)
   );

endmodule // clkgen_host

// [clkgen_host_regs.vh]
// Constants for the clock generator host controller.
// Assumes the device register port carries byte addresses and the
// target register byte in data bits 7:0, or a full word with all lanes.
`ifndef CLKGEN_HOST_REGS_VH
`define CLKGEN_HOST_REGS_VH

// ========================================================
// Clock and timing
`define CLK_PERIOD_NS        8
`define SUB_STAB_TIME_US     2000
`define MAIN_STAB_TIME_US    100

// ========================================================
// Control and status register word addresses (Avalon side)
`define CSR_CMD              2'h0
`define CSR_DIV              2'h1
`define CSR_MISC             2'h2
`define CSR_READ             2'h3

// Command codes
`define CMD_NONE             3'h0
`define CMD_START_SUB        3'h1
`define CMD_SWITCH_SUB       3'h2
`define CMD_SET_DIV          3'h3
`define CMD_MAIN_CTRL        3'h4
`define CMD_CLEAR_STOP       3'h5
`define CMD_SET_MODE2        3'h6
`define CMD_READ             3'h7

// Command register status bits
`define ST_BUSY_BIT          8
`define ST_ERR_BIT           9

// Divider field layout, shared by CSR_DIV and the device divider register
`define DIV_BASE_LSB         0
`define DIV_CPU_LSB          2
`define DIV_PERIPH_LSB       4
`define DIV_FIELD_W          2
`define DIV_ONCE_BIT         6
`define DIV_BASE_SRC_BIT     7

// Misc CSR fields
`define MISC_EXT_SUB_BIT     0
`define MISC_STOP_DET_BIT    1
`define MISC_MAIN_DIS_BIT    2
`define MISC_WAIT_STOP_BIT   3
`define MISC_LS_SEL_LSB      4
`define MISC_MODE2_LSB       8

// ========================================================
// Device register byte addresses
`define DEV_CLK_DIV_ADDR     16'h0004
`define DEV_PROT_KEY_ADDR    16'h0008
`define DEV_PROT_ADDR        16'h000a
`define DEV_OSC0_ADDR        16'h0010
`define DEV_OSC1_ADDR        16'h0011
`define DEV_OSC2_ADDR        16'h0012
`define DEV_LOW_SPEED_ADDR   16'h0013
`define DEV_MODE2_ADDR       16'h0014
`define DEV_PORT_DIR_ADDR    16'h0015
`define DEV_PULLUP_ADDR      16'h0016

// Device field values
`define KEY_UNLOCK           8'haa
`define KEY_LOCK             8'h00
`define PROT_OSC_UNLOCK      8'h01
`define PROT_MODE2_UNLOCK    8'h02
`define PROT_NONE            8'h00
`define OSC0_WAIT_STOP_BIT   2
`define OSC0_SUB_EN_BIT      4
`define OSC0_MAIN_DIS_BIT    5
`define OSC1_STOP_STAT_BIT   5
`define OSC2_DET_EN_BIT      0
`define SUB_IN_DIR_BIT       6
`define SUB_OUT_DIR_BIT      7
`define SUB_PULLUP_BIT       5
`define LS_SEL_SUB           2'h0
`define LS_SEL_MAIN256       2'h2
`define BYTE_ZERO            8'h00

// Step encoding
`define OP_END               2'h0
`define OP_WR                2'h1
`define OP_RD                2'h2
`define OP_WAIT              2'h3
`define BE_BYTE              4'h1
`define BE_WORD              4'hf
`define WAIT_SUB             32'h0000_0000
`define WAIT_MAIN            32'h0000_0001

`endif

// [clkgen_host_sva.sv]
// Checker for the clock generator host controller.
// Assumes it is bound to clkgen_host and sees only its ports.
`timescale 1ns/10ps
module clkgen_host_sva #(
   parameter SUB_STAB_CYC  = 8,
   parameter MAIN_STAB_CYC = 8
) (
   input wire        CLK_I,
   input wire        RST_N_I,
   input wire [1:0]  AVS_ADDRESS_I,
   input wire        AVS_READ_I,
   input wire        AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [31:0] AVS_READDATA_O,
   input wire        AVS_WAITREQUEST_O,
   input wire        DEV_REQ_O,
   input wire        DEV_WE_O,
   input wire [15:0] DEV_ADDR_O,
   input wire [31:0] DEV_WDATA_O,
   input wire [3:0]  DEV_BE_O,
   input wire        DEV_ACK_I,
   input wire [31:0] DEV_RDATA_I
);
   reg        req_q;
   reg  [7:0] key_q, prot_q, dir_q, pu_q, ls_q, div_q;
   wire       wr_st = DEV_REQ_O && DEV_WE_O && !req_q;
   wire [7:0] wd    = DEV_WDATA_O[7:0];
   wire       at_div = DEV_ADDR_O == 16'h0004;
   // ====
   // Device state as left by the host's writes
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         req_q <= 1'b0;
         {key_q, prot_q, dir_q, pu_q, ls_q, div_q} <= 48'h0000_ffff_ff00;
      end else begin
         req_q <= DEV_REQ_O;
         if (wr_st) begin
            case (DEV_ADDR_O)
               16'h0004: div_q <= wd;
               16'h0008: key_q <= wd;
               16'h000a: prot_q <= wd;
               16'h0013: ls_q <= wd;
               16'h0015: dir_q <= wd;
               16'h0016: pu_q <= wd;
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   chk_avs_one_wait: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O) else $error("bus wait not one cycle");
   chk_ack_release: assert property ($rose(DEV_ACK_I) |-> ##[1:5] !DEV_REQ_O)
      else $error("request held after ack");
   chk_div_key: assert property (wr_st && at_div |-> key_q == 8'haa)
      else $error("divider write without key");
   chk_osc_unlock: assert property (wr_st && DEV_ADDR_O[15:2] == 14'h0004 && DEV_ADDR_O[1:0] != 2'h3
      |-> prot_q[0]) else $error("osc write while protected");
   chk_mode2_unlock: assert property (wr_st && DEV_ADDR_O == 16'h0014 |-> prot_q[1])
      else $error("mode 2 write while protected");
   chk_div_word: assert property (DEV_REQ_O && at_div |-> DEV_BE_O == 4'hf)
      else $error("divider access not a full word");
   chk_div_split: assert property (wr_st && at_div |-> wd[1:0] == div_q[1:0] || wd[5:4] == div_q[5:4])
      else $error("base and periph ratio changed together");
   chk_sub_pins: assert property (wr_st && DEV_ADDR_O == 16'h0010 && wd[4]
      |-> dir_q[7:6] == 2'h0 && !pu_q[5]) else $error("sub enable before pin setup");
   chk_sub_switch: assert property (wr_st && at_div && wd[7] |-> ls_q == 8'h00)
      else $error("base source set before sub select");
   cov_div_write: cover property (wr_st && at_div);
   cov_sub_start: cover property (wr_st && DEV_ADDR_O == 16'h0010 && wd[4]);
   cov_mode2_write: cover property (wr_st && DEV_ADDR_O == 16'h0014);
endmodule // clkgen_host_sva

bind clkgen_host clkgen_host_sva #(.SUB_STAB_CYC(SUB_STAB_CYC), .MAIN_STAB_CYC(MAIN_STAB_CYC)) clkgen_host_sva_inst (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .DEV_REQ_O(DEV_REQ_O), .DEV_WE_O(DEV_WE_O), .DEV_ADDR_O(DEV_ADDR_O),
   .DEV_WDATA_O(DEV_WDATA_O), .DEV_BE_O(DEV_BE_O), .DEV_ACK_I(DEV_ACK_I), .DEV_RDATA_I(DEV_RDATA_I));

// [clkgen_host_test.sv]
// Self-checking testbench for the clock generator host controller.
// Assumes the device model on the device port and shortened settle waits.
`timescale 1ns/10ps
`include "clkgen_host_regs.vh"
module clkgen_host_test;
   reg         clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, stop = 1'b0;
   reg  [1:0]  adr = 2'h0;
   reg  [3:0]  dly = 4'h0;
   reg  [15:0] m;
   reg  [31:0] wdat = 32'h0, q;
   wire [31:0] rdat, dev_wdata, dev_rdata;
   wire        wreq, dev_req, dev_we, dev_ack;
   wire [15:0] dev_addr;
   wire [3:0]  dev_be;
   wire [7:0]  osc0 = clkgen_dev_model_inst.osc0_q, osc1 = clkgen_dev_model_inst.osc1_q;
   wire [7:0]  osc2 = clkgen_dev_model_inst.osc2_q, divr = clkgen_dev_model_inst.div_q;
   integer     errors = 0, n_tests = 0, cyc = 0, i;
   clkgen_host #(.SUB_STAB_CYC(8), .MAIN_STAB_CYC(8)) clkgen_host_inst (
      .CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .DEV_REQ_O(dev_req),
      .DEV_WE_O(dev_we), .DEV_ADDR_O(dev_addr), .DEV_WDATA_O(dev_wdata), .DEV_BE_O(dev_be),
      .DEV_ACK_I(dev_ack), .DEV_RDATA_I(dev_rdata));
   clkgen_dev_model clkgen_dev_model_inst (
      .clk_i(clk), .rst_n_i(rst_n), .req_i(dev_req), .we_i(dev_we), .addr_i(dev_addr), .wdata_i(dev_wdata),
      .be_i(dev_be), .dly_i(dly), .stop_i(stop), .ack_o(dev_ack), .rdata_o(dev_rdata));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         finish_test;
      end
   end
   // ====
   // Bus and checking tasks
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR at %0t: seen %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task av(input w, input [1:0] a, input [31:0] d);
      begin
         @(posedge clk);
         {adr, wdat, wr, rd} <= {a, d, w, !w};
         @(posedge clk);
         while (wreq !== 1'b0) @(posedge clk);
         q = rdat;
         {wr, rd} <= 2'b00;
      end
   endtask
   task run(input [2:0] c, input [15:0] misc);
      begin
         av(1'b1, `CSR_MISC, {16'h0, misc});
         av(1'b1, `CSR_CMD, {29'h0, c});
         q = 32'h100;
         while (q[`ST_BUSY_BIT] !== 1'b0) av(1'b0, `CSR_CMD, 32'h0);
      end
   endtask
   task finish_test;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // ====
   // Test sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      av(1'b0, `CSR_CMD, 32'h0);
      chk(q[9:0], 32'h0);
      chk(osc0[4], 1'b0);
      run(`CMD_START_SUB, 16'h0000);
      chk(osc0[4], 1'b1);
      $display("test sub start done");
      dly <= 4'h5;
      av(1'b1, `CSR_DIV, 32'h1c);
      run(`CMD_SET_DIV, 16'h0000);
      chk({q[9:8], divr}, 32'h200);
      av(1'b1, `CSR_DIV, 32'h65);
      run(`CMD_SET_DIV, 16'h0000);
      chk(divr, 32'h65);
      run(`CMD_SWITCH_SUB, 16'h0000);
      chk({clkgen_dev_model_inst.ls_q, divr}, 32'he5);
      $display("test divider done");
      for (i = 0; i < 3; i = i + 1) begin
         {q, m} = 48'h0006_000a_0022 >> (32 - 16 * i);
         run(`CMD_MAIN_CTRL, m);
         chk({osc0[5], osc0[2], osc2[0]}, {m[2], m[3], m[1] & !m[2] & (m[5:4] != 2'h2)});
      end
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      @(negedge clk);
      chk({osc1[5], osc2[2]}, 2'h3);
      run(`CMD_CLEAR_STOP, 16'h0002);
      chk({osc1[5], osc2[2]}, 2'h0);
      $display("test main control done");
      run(`CMD_SET_MODE2, 16'h0200);
      run(`CMD_SET_MODE2, 16'h0000);
      av(1'b1, `CSR_READ, 32'h0014);
      run(`CMD_READ, 16'h0000);
      av(1'b0, `CSR_READ, 32'h0);
      chk(q, 32'h2);
      $display("test mode 2 done");
      finish_test;
   end
endmodule // clkgen_host_test

// [dev_port.v]
// Four-phase request/acknowledge access port towards the device.
// Assumes the device holds read data stable while it acknowledges.
`timescale 1ns/10ps
`include "clkgen_host_regs.vh"

module dev_port (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        start_i,
   input  wire        we_i,
   input  wire [15:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire [3:0]  be_i,
   output reg         done_o,
   output reg  [31:0] rdata_o,
   output reg         dev_req_o,
   output reg         dev_we_o,
   output reg  [15:0] dev_addr_o,
   output reg  [31:0] dev_wdata_o,
   output reg  [3:0]  dev_be_o,
   input  wire        dev_ack_i,
   input  wire [31:0] dev_rdata_i
);

   reg        ack_meta_q;
   reg        ack_q;
   reg [31:0] rd_meta_q;
   reg [31:0] rd_sync_q;
   reg        wait_low_q;

   // ========================================================
   // Input synchronisers
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_meta_q <= 1'b0;
         ack_q      <= 1'b0;
         rd_meta_q  <= 32'h0000_0000;
         rd_sync_q  <= 32'h0000_0000;
      end else begin
         ack_meta_q <= dev_ack_i;
         ack_q      <= ack_meta_q;
         rd_meta_q  <= dev_rdata_i;
         rd_sync_q  <= rd_meta_q;
      end
   end

   // ========================================================
   // Handshake
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dev_req_o   <= 1'b0;
         dev_we_o    <= 1'b0;
         dev_addr_o  <= 16'h0000;
         dev_wdata_o <= 32'h0000_0000;
         dev_be_o    <= 4'h0;
         done_o      <= 1'b0;
         rdata_o     <= 32'h0000_0000;
         wait_low_q  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !dev_req_o && !wait_low_q) begin
            dev_req_o   <= 1'b1;
            dev_we_o    <= we_i;
            dev_addr_o  <= addr_i;
            dev_wdata_o <= wdata_i;
            dev_be_o    <= be_i;
         end else if (dev_req_o && ack_q) begin
            dev_req_o  <= 1'b0;
            rdata_o    <= rd_sync_q;
            wait_low_q <= 1'b1;
         end else if (wait_low_q && !ack_q) begin
            wait_low_q <= 1'b0;
            done_o     <= 1'b1;
         end
      end
   end

endmodule // dev_port
